// ---- version_capability_responder.sv ----
// module: answers the version and capability queries byte by byte
`timescale 1ns/1ps
`default_nettype none
module version_capability_responder #(
	parameter logic [7:0] VER_MAJOR = 8'hF1,
	parameter logic [7:0] VER_MINOR = 8'h11,
	parameter logic [7:0] VER_UPDATE = 8'hF1,
	parameter logic [7:0] VER_FIRST_SUFFIX_CHAR = 8'h00,
	parameter logic [7:0] VER_SECOND_SUFFIX_CHAR = 8'h00,
	parameter logic [95:0] FW_NAME = 96'h0000_0000_0000_0000_0000_0000,
	parameter logic [31:0] FW_VERSION = 32'h0000_0000,
	parameter bit HOST_BUS_SHARED = 1'b0,
	// identifier values are arbitrary
	parameter logic [15:0] BUS_DID = 16'h1234,
	parameter logic [15:0] BUS_VID = 16'h5678,
	parameter logic [15:0] BUS_SSID = 16'h0001,
	parameter logic [15:0] BUS_SVID = 16'h0002,
	parameter bit MFR_USED = 1'b0,
	parameter logic [31:0] MFR_NUMBER = 32'h0000_0000,
	parameter logic [31:0] CAP_FLAGS = 32'h0000_0000,
	parameter logic [31:0] BCAST_MASK = 32'h0000_0000,
	parameter logic [31:0] MCAST_MASK = 32'h0000_0000,
	parameter logic [31:0] BUFFER_BYTES = 32'h0000_0000,
	parameter logic [31:0] EVENT_SUPPORT = 32'h0000_0000,
	parameter int VLAN_FILTERS = 1,
	parameter int MIXED_FILTERS = 0,
	parameter int MCAST_FILTERS = 0,
	parameter int UCAST_FILTERS = 1,
	parameter logic [7:0] VLAN_MODES = 8'h01,
	parameter logic [7:0] CHANNEL_COUNT = 8'h01
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic CMD_VALID_I,
	input wire logic [7:0] CMD_CODE_I,
	output logic CMD_READY_O,
	output logic [7:0] RESP_TYPE_O,
	output logic [7:0] RESP_DATA_O,
	output logic RESP_VALID_O,
	output logic RESP_LAST_O,
	input wire logic RESP_READY_I
);
	import ident_resp_pkg::*;

	// ******************************
	// elaboration checks
	// ******************************
	function automatic bit bcd_ok(input logic [7:0] b, input bit allow_ff);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = b[7:4];
		lo = b[3:0];
		if (b == BCD_ABSENT)
			return allow_ff;
		return (lo <= 4'd9) && ((hi <= 4'd9) || (hi == NIBBLE_IGNORE));
	endfunction

	initial begin
		if (!bcd_ok(VER_MAJOR, 1'b0) || !bcd_ok(VER_MINOR, 1'b0))
			$error("major or minor not valid BCD");
		if (!bcd_ok(VER_UPDATE, 1'b1))
			$error("update not valid BCD");
		if (VER_FIRST_SUFFIX_CHAR == CHAR_NONE && VER_SECOND_SUFFIX_CHAR != CHAR_NONE)
			$error("second suffix char used before first");
		if (VLAN_FILTERS < 0 || VLAN_FILTERS > VLAN_FILTER_MAX)
			$error("vlan filter count too large");
		if (MIXED_FILTERS < 0 || MCAST_FILTERS < 0 || UCAST_FILTERS < 0 ||
			MIXED_FILTERS + MCAST_FILTERS + UCAST_FILTERS > ADDR_FILTER_MAX)
			$error("address filter total too large");
		if (UCAST_FILTERS + MIXED_FILTERS < 1)
			$error("need a unicast or mixed filter");
		if ((CAP_FLAGS & ~CAP_FLAG_MASK) != 32'h0000_0000 || CAP_FLAGS[6:5] == 2'b11)
			$error("reserved capability flag bits set");
		if ((VLAN_MODES & ~VLAN_MODE_MASK) != 8'h00)
			$error("reserved vlan mode bits set");
	end

	// ******************************
	// row contents
	// ******************************
	// name: keep bytes up to first zero, zero the rest
	function automatic logic [95:0] clean_name(input logic [95:0] n);
		logic [95:0] r;
		bit ended;
		r = 96'h0;
		ended = 1'b0;
		for (int i = 11; i >= 0; i--) begin
			if (!ended)
				r[i*8 +: 8] = n[i*8 +: 8];
			if (n[i*8 +: 8] == CHAR_NONE)
				ended = 1'b1;
		end
		return r;
	endfunction

	localparam logic [95:0] NAME_C = clean_name(FW_NAME);
	localparam logic [7:0] VLAN_C = 8'(VLAN_FILTERS);
	localparam logic [7:0] MIXED_C = 8'(MIXED_FILTERS);
	localparam logic [7:0] MCAST_C = 8'(MCAST_FILTERS);
	localparam logic [7:0] UCAST_C = 8'(UCAST_FILTERS);

	function automatic logic [31:0] row_word(input logic is_ver, input logic [3:0] idx);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (idx == 4'h0) begin
			w = {RESP_CODE_OK, REASON_NONE};
		end else if (is_ver) begin
			case (idx)
				4'h1: w = {VER_MAJOR, VER_MINOR, VER_UPDATE, VER_FIRST_SUFFIX_CHAR};
				4'h2: w = {24'h00_0000, VER_SECOND_SUFFIX_CHAR};
				4'h3: w = NAME_C[95:64];
				4'h4: w = NAME_C[63:32];
				4'h5: w = NAME_C[31:0];
				4'h6: w = FW_VERSION;
				4'h7: w = HOST_BUS_SHARED ? {BUS_DID, BUS_VID} : 32'h0000_0000;
				4'h8: w = HOST_BUS_SHARED ? {BUS_SSID, BUS_SVID} : 32'h0000_0000;
				4'h9: w = MFR_USED ? MFR_NUMBER : MFR_UNUSED;
				default: w = 32'h0000_0000;
			endcase
		end else begin
			case (idx)
				4'h1: w = CAP_FLAGS & CAP_FLAG_MASK;
				4'h2: w = BCAST_MASK;
				4'h3: w = MCAST_MASK;
				4'h4: w = BUFFER_BYTES;
				4'h5: w = EVENT_SUPPORT;
				4'h6: w = {VLAN_C, MIXED_C, MCAST_C, UCAST_C};
				4'h7: w = {16'h0000, VLAN_MODES & VLAN_MODE_MASK, CHANNEL_COUNT};
				default: w = 32'h0000_0000;
			endcase
		end
		return w;
	endfunction

	// ******************************
	// sequencer
	// ******************************
	typedef enum logic [1:0] {IDLE, SEND} state_t;
	state_t state_r;
	logic is_ver_r;
	logic [7:0] type_r;
	logic [3:0] row_r;
	logic [3:0] row_nxt;
	logic [1:0] byte_r;
	logic [1:0] byte_nxt;
	logic [7:0] data_r;
	logic last_r;
	logic last_nxt;
	logic [31:0] word;
	logic [31:0] head_word;
	logic [3:0] last_row;
	logic known;
	logic cmd_is_ver;
	logic accept;
	logic adv;
	logic step;
	logic done;

	// ******************************
	// byte select
	// ******************************
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] idx);
		logic [7:0] b;
		case (idx)
			2'h0: b = w[31:24];
			2'h1: b = w[23:16];
			2'h2: b = w[15:8];
			default: b = w[7:0];
		endcase
		return b;
	endfunction

	// ******************************
	// handshake
	// ******************************
	// the checksum row is outside this block; queries carry no payload
	// unknown codes are taken and dropped
	assign known = (CMD_CODE_I == CMD_GET_VERSION) || (CMD_CODE_I == CMD_GET_CAPS);
	assign cmd_is_ver = (CMD_CODE_I == CMD_GET_VERSION);
	// both handshakes fall while the clock enable is low
	assign CMD_READY_O = CE_I && (state_r == IDLE);
	assign accept = CMD_READY_O && CMD_VALID_I && known;
	assign RESP_VALID_O = CE_I && (state_r == SEND);
	assign adv = RESP_VALID_O && RESP_READY_I;
	assign step = adv && !last_r;
	assign done = adv && last_r;

	// ******************************
	// position of the following byte
	// ******************************
	assign last_row = is_ver_r ? VER_LAST : CAP_LAST;
	assign byte_nxt = byte_r + 2'h1;
	assign row_nxt = (byte_r == 2'h3) ? (row_r + 4'h1) : row_r;
	assign last_nxt = (row_nxt == last_row) && (byte_nxt == 2'h3);
	assign word = row_word(is_ver_r, row_nxt);
	assign head_word = row_word(cmd_is_ver, 4'h0);

	// ******************************
	// state
	// ******************************
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_r <= IDLE;
		end else if (accept) begin
			state_r <= SEND;
		end else if (done) begin
			state_r <= IDLE;
		end
	end

	// ******************************
	// command capture
	// ******************************
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			is_ver_r <= 1'b0;
			type_r <= RESET_BYTE;
		end else if (accept) begin
			is_ver_r <= cmd_is_ver;
			type_r <= cmd_is_ver ? RESP_VERSION : RESP_CAPS;
		end
	end

	// ******************************
	// byte within row, top byte first
	// ******************************
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			byte_r <= 2'h0;
		end else if (accept) begin
			byte_r <= 2'h0;
		end else if (step) begin
			byte_r <= byte_nxt;
		end
	end

	// ******************************
	// row
	// ******************************
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			row_r <= 4'h0;
		end else if (accept) begin
			row_r <= 4'h0;
		end else if (step) begin
			row_r <= row_nxt;
		end
	end

	// ******************************
	// data register
	// ******************************
	// first byte loaded on accept, next one on each taken byte but the last
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			data_r <= RESET_BYTE;
		end else if (accept) begin
			data_r <= pick_byte(head_word, 2'h0);
		end else if (step) begin
			data_r <= pick_byte(word, byte_nxt);
		end
	end

	// ******************************
	// last flag
	// ******************************
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			last_r <= 1'b0;
		end else if (accept) begin
			last_r <= 1'b0;
		end else if (adv) begin
			last_r <= last_nxt;
		end
	end

	// ******************************
	// outputs
	// ******************************
	assign RESP_TYPE_O = type_r;
	assign RESP_DATA_O = data_r;
	assign RESP_LAST_O = last_r;
endmodule
`default_nettype wire

// ---- ident_resp_pkg.sv ----
// package: constants for the version and capability responder
package ident_resp_pkg;
	// ******************************
	// command and response codes
	// ******************************
	localparam logic [7:0] CMD_GET_VERSION = 8'h15;
	localparam logic [7:0] CMD_GET_CAPS = 8'h16;
	localparam logic [7:0] RESP_VERSION = 8'h95;
	localparam logic [7:0] RESP_CAPS = 8'h96;
	localparam logic [15:0] RESP_CODE_OK = 16'h0000;
	localparam logic [15:0] REASON_NONE = 16'h0000;
	// ******************************
	// payload lengths in 32-bit rows, response/reason row included
	// ******************************
	localparam int VER_ROWS = 10;
	localparam int CAP_ROWS = 8;
	localparam logic [3:0] VER_LAST = 4'h9;
	localparam logic [3:0] CAP_LAST = 4'h7;
	// ******************************
	// fixed values
	// ******************************
	localparam logic [31:0] MFR_UNUSED = 32'hFFFF_FFFF;
	localparam logic [7:0] BCD_ABSENT = 8'hFF;
	localparam logic [3:0] NIBBLE_IGNORE = 4'hF;
	localparam logic [7:0] CHAR_NONE = 8'h00;
	localparam int VLAN_FILTER_MAX = 15;
	localparam int ADDR_FILTER_MAX = 8;
	localparam logic [31:0] CAP_FLAG_MASK = 32'h0000_007D;
	localparam logic [7:0] VLAN_MODE_MASK = 8'h07;
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// ---- vcr_checker.sv ----
// checker: response stream properties of the responder
`timescale 1ns/1ps
`default_nettype none
module vcr_checker (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic CMD_VALID_I,
	input wire logic [7:0] CMD_CODE_I,
	input wire logic CMD_READY_O,
	input wire logic [7:0] RESP_TYPE_O,
	input wire logic [7:0] RESP_DATA_O,
	input wire logic RESP_VALID_O,
	input wire logic RESP_LAST_O,
	input wire logic RESP_READY_I
);
	import ident_resp_pkg::*;
	logic ver_r;
	logic [5:0] beat_r;
	wire logic tk = RESP_VALID_O && RESP_READY_I;
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) ver_r <= 1'b0;
		else if (CE_I && CMD_VALID_I && CMD_READY_O &&
			(CMD_CODE_I == CMD_GET_VERSION || CMD_CODE_I == CMD_GET_CAPS))
			ver_r <= CMD_CODE_I == CMD_GET_VERSION;
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I || (tk && RESP_LAST_O)) beat_r <= 6'h00;
		else if (tk) beat_r <= beat_r + 6'h01;
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	property p_vt; RESP_VALID_O && ver_r |-> RESP_TYPE_O == RESP_VERSION; endproperty
	a_vt: assert property (p_vt) else $error("type");
	property p_ct; RESP_VALID_O && !ver_r |-> RESP_TYPE_O == RESP_CAPS; endproperty
	a_ct: assert property (p_ct) else $error("type");
	property p_hold; RESP_VALID_O && !RESP_READY_I |=> (RESP_VALID_O || !CE_I) && $stable(RESP_DATA_O);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_vl; tk && RESP_LAST_O && ver_r |-> beat_r == 6'h27; endproperty
	a_vl: assert property (p_vl) else $error("len");
	property p_cl; tk && RESP_LAST_O && !ver_r |-> beat_r == 6'h1F; endproperty
	a_cl: assert property (p_cl) else $error("len");
	property p_rc; RESP_VALID_O && beat_r < 6'h04 |-> RESP_DATA_O == 8'h00; endproperty
	a_rc: assert property (p_rc) else $error("code");
	property p_fl; RESP_VALID_O && !ver_r && beat_r inside {6'h04, 6'h05, 6'h06} |-> !RESP_DATA_O; endproperty
	a_fl: assert property (p_fl) else $error("flags");
	property p_vf; RESP_VALID_O && !ver_r && beat_r == 6'h18 |-> RESP_DATA_O <= 8'h0F; endproperty
	a_vf: assert property (p_vf) else $error("vlan");
endmodule
bind version_capability_responder vcr_checker chk (.*);
`default_nettype wire

// ---- mc_model.sv ----
// model: management controller issuing queries and taking bytes
`timescale 1ns/1ps
`default_nettype none
module mc_model (
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic slow_i,
	output logic valid_o = 1'b0,
	output logic [7:0] code_o = 8'h00,
	output logic take_o = 1'b0
);
	always @(posedge clk_i) take_o <= #1 slow_i ? ~take_o : 1'b1;
	task automatic send(input logic [7:0] c);
		valid_o = 1'b1;
		code_o = c;
		do @(posedge clk_i); while (!ready_i);
		#1 valid_o = 1'b0;
		code_o = ~c;
	endtask
endmodule
`default_nettype wire

// ---- version_capability_responder_tb.sv ----
// testbench: version and capability query scenarios
`timescale 1ns/1ps
`default_nettype none
module version_capability_responder_tb;
	import ident_resp_pkg::*;
	logic clk = 1'b0, rst = 1'b1, slow = 1'b0, ce = 1'b1, stall = 1'b0;
	wire logic cv, cr, rv, rl, rr;
	wire logic [7:0] cc, rt, rd;
	int fails = 0, total_checks = 0, cyc = 0;
	logic [31:0] eq[$];
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) ce <= #1 !stall || !ce;
	mc_model mc (.clk_i(clk), .ready_i(cr), .slow_i(slow), .valid_o(cv), .code_o(cc), .take_o(rr));
	version_capability_responder #(.VER_FIRST_SUFFIX_CHAR(8'h41), .FW_NAME(96'h4142_4300_0000_0000_0000_0000),
		.FW_VERSION(32'h0003_0217), .CAP_FLAGS(32'h15), .VLAN_FILTERS(15)) dut (.CORE_CLK_I(clk),
		.RST_I(rst), .CE_I(ce), .CMD_VALID_I(cv), .CMD_CODE_I(cc), .CMD_READY_O(cr),
		.RESP_TYPE_O(rt), .RESP_DATA_O(rd), .RESP_VALID_O(rv), .RESP_LAST_O(rl), .RESP_READY_I(rr));
	task automatic print_verdict(input int late = 0);
		fails += late;
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) if (++cyc > 3000) print_verdict(1);
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		fails += int'(g !== e);
		if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
	endtask
	task automatic query(input logic [7:0] c, input logic [7:0] t);
		int b = 0;
		mc.send(c);
		while (b < eq.size() * 4) begin
			@(negedge clk);
			if (rv && rr) begin
				cmp(rd, eq[b / 4][31 - 8 * (b % 4) -: 8]);
				cmp(rt, t);
				cmp({7'h00, rl}, {7'h00, b == eq.size() * 4 - 1});
				b++;
			end
		end
		@(posedge clk) #1;
	endtask
	task automatic test_version();
		eq = '{32'h0, 32'hF111_F141, 32'h0, 32'h4142_4300, 32'h0, 32'h0, 32'h0003_0217,
			32'h0, 32'h0, MFR_UNUSED};
		query(CMD_GET_VERSION, RESP_VERSION);
	endtask
	task automatic test_caps();
		eq = '{32'h0, 32'h15, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0F00_0001, 32'h0000_0101};
		query(CMD_GET_CAPS, RESP_CAPS);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		test_version();
		slow = 1'b1;
		test_caps();
		slow = 1'b0;
		stall = 1'b1;
		test_version();
		print_verdict();
	end
endmodule
`default_nettype wire
